//--- event_flag_bank.sv
// Purpose: Eight sticky flags, each set by a pulse and cleared by a strobe.
// Assumes: Set and clear strobes are synchronous to clk_i.
// Notes:   A set in the clearing cycle wins, so no event is lost.
`timescale 1ns/10ps
`include "usb_evt_regs.svh"
module event_flag_bank (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    // Set and clear strobes
    input  wire logic [7:0] set_i,
    input  wire logic [7:0] clr_i,
    // Flags
    output logic      [7:0] flag_o
);

    logic [7:0] flag_reg;
    logic [7:0] flag_next;

    // Set has priority over clear in the same cycle.
    assign flag_next = set_i | (flag_reg & ~clr_i);
    assign flag_o    = flag_reg;

    // Flag storage.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flag_reg <= `REG_RESET;
        end else begin
            flag_reg <= flag_next;
        end
    end

endmodule

//--- level_timer.sv
// Purpose: Fires one pulse once a level has held for LIMIT consecutive cycles.
// Assumes: LIMIT is at least one and below 2**17.
// Notes:   The counter saturates, so a long level fires only once.
`timescale 1ns/10ps
module level_timer #(
    parameter int unsigned LIMIT = 50
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    // Watched level and result
    input  wire logic level_i,
    output logic      fire_o
);

    logic [16:0] count_reg;
    logic [16:0] count_next;
    logic        at_limit;

    // Restart whenever the level drops; hold at the limit afterwards.
    assign at_limit   = (count_reg == 17'(LIMIT));
    assign count_next = !level_i ? 17'h00000 : (at_limit ? count_reg : count_reg + 17'h00001);
    assign fire_o     = level_i && (count_reg == 17'(LIMIT - 1));

    // Run length counter.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count_reg <= 17'h00000;
        end else begin
            count_reg <= count_next;
        end
    end

endmodule

//--- upstream_host_model.sv
// Purpose: Upstream host and frame timer conditions seen by the event block.
// Assumes: Bench clock; every level changes just after a rising edge.
// Notes:   Levels rest low except unlocked, which starts set like a fresh frame timer.
`timescale 1ns/10ps
module upstream_host_model (
    // Clock
    input  wire logic clk_i,
    // Conditions toward the device: se0, idle, resume, eop, frame, unlocked
    output logic [5:0] lv_o
);
    // A quiet bus; the device may see SE0 only while a stretch is commanded.
    initial begin
        lv_o = 6'h20;
    end

    // Holds one condition for n sampled cycles, then releases it (n = 1 gives a pulse).
    task automatic hold(input int which, input int n);
        @(posedge clk_i) lv_o[which] <= 1'b1;
        repeat (n) @(posedge clk_i);
        lv_o[which] <= 1'b0;
    endtask

    // Moves the frame timer between locked and unlocked.
    task automatic set_unlocked(input logic v);
        @(posedge clk_i) lv_o[5] <= v;
    endtask
endmodule

//--- usb_evt_pkg.sv
// Purpose: Types shared by the event aggregation block.
// Assumes: Node state codes follow the declaration order 00, 01, 10, 11.
// Notes:   Offsets and counts live in usb_evt_regs.svh.
package usb_evt_pkg;

    // Node functional state; the declaration order gives the two-bit codes.
    typedef enum logic [1:0] {
        state_bus_clear,
        state_wake_signal,
        state_running,
        state_asleep
    } node_state_e;

    typedef logic [7:0] byte_t;

endpackage

//--- usb_evt_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the event block.
// Assumes: Byte-wide register port with a six-bit address, 20 MHz core clock.
// Notes:   Definitions only; included by every design file that needs them.
`ifndef USB_EVT_REGS_SVH
`define USB_EVT_REGS_SVH

// Register offsets on the byte-wide register port.
`define OFF_NODE_STATE   6'h06
`define OFF_MAIN_EVENT   6'h07
`define OFF_MAIN_MASK    6'h08
`define OFF_SEC_EVENT    6'h09
`define OFF_SEC_MASK     6'h0A
`define OFF_TX_EVENT     6'h0B
`define OFF_TX_MASK      6'h0C
`define OFF_RX_EVENT     6'h0D
`define OFF_RX_MASK      6'h0E
`define OFF_NAK_EVENT    6'h0F
`define OFF_NAK_MASK     6'h10
`define OFF_FW_EVENT     6'h11
`define OFF_FW_MASK      6'h12

// Main event register bit positions.
`define MAIN_WARN_BIT    0
`define MAIN_SEC_BIT     1
`define MAIN_TX_BIT      2
`define MAIN_FRAME_BIT   3
`define MAIN_NAK_BIT     4
`define MAIN_LOCK_BIT    5
`define MAIN_RX_BIT      6
`define MAIN_MASTER_BIT  7

// Secondary event register bit positions.
`define SEC_EOP_BIT      3
`define SEC_IDLE3_BIT    4
`define SEC_IDLE5_BIT    5
`define SEC_BUSZERO_BIT  6
`define SEC_WAKE_BIT     7

// Reset values.
`define REG_RESET        8'h00

// Timing: figures as printed, cycle counts derived from the clock period.
`define CLK_PERIOD_NS    50
`define BUSZERO_TIME_NS  2500
`define IDLE3_TIME_MS    3
`define IDLE5_TIME_MS    5
`define BUSZERO_CYCLES   ((`BUSZERO_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IDLE3_CYCLES     ((`IDLE3_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define IDLE5_CYCLES     ((`IDLE5_TIME_MS * 1000000) / `CLK_PERIOD_NS)

`endif

//--- usb_node_event_aggregator.sv
// Purpose: Event flags, masks, summary bits, interrupt and node state of a USB function.
// Assumes: Register strobes last one cycle; bus and endpoint inputs are synchronous.
// Notes:   Read data is registered and appears on the edge that also clears read flags.
`timescale 1ns/10ps
`include "usb_evt_regs.svh"

module usb_node_event_aggregator #(
    parameter int unsigned IDLE3_CYCLES = `IDLE3_CYCLES,
    parameter int unsigned IDLE5_CYCLES = `IDLE5_CYCLES
) (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    // Register port
    input  wire logic [5:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    // Upstream bus conditions
    input  wire logic       bus_se0_i,
    input  wire logic       bus_idle_i,
    input  wire logic       resume_seen_i,
    input  wire logic       eop_seen_i,
    // Frame timer
    input  wire logic       frame_update_i,
    input  wire logic       unlocked_flag_i,
    // Transmit endpoints
    input  wire logic [3:0] tx_done_i,
    input  wire logic [3:0] tx_underflow_i,
    input  wire logic [3:0] tx_status_read_i,
    // Receive endpoints
    input  wire logic [3:0] rx_final_i,
    input  wire logic [3:0] rx_fault_i,
    input  wire logic [3:0] rx_overrun_i,
    input  wire logic [3:0] rx_status_read_i,
    // Handshake refusals
    input  wire logic [3:0] nak_in_i,
    input  wire logic [3:0] nak_out_i,
    // FIFO warning levels
    input  wire logic [3:1] tx_warn_i,
    input  wire logic [3:1] rx_warn_i,
    // Node control and interrupt
    output logic            irq_o,
    output logic      [1:0] node_state_field_o,
    output logic            ep_disable_o,
    output logic            suspend_o,
    output logic            freeze_o,
    output logic            resume_k_o
);

    // Register hit on the current address.
    function automatic logic addr_hit(input logic [5:0] addr, input logic [5:0] offset);
        return addr == offset;
    endfunction

    usb_evt_pkg::node_state_e node_state_reg;
    usb_evt_pkg::byte_t       main_mask_reg;
    usb_evt_pkg::byte_t       sec_mask_reg;
    usb_evt_pkg::byte_t       tx_mask_reg;
    usb_evt_pkg::byte_t       rx_mask_reg;
    usb_evt_pkg::byte_t       nak_mask_reg;
    usb_evt_pkg::byte_t       fw_mask_reg;
    usb_evt_pkg::byte_t       rdata_reg;
    logic [7:0]               fw_prev_reg;
    logic                     unlocked_prev_reg;

    logic [7:0] main_q;
    logic [7:0] sec_q;
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    logic [7:0] nak_q;
    logic [7:0] main_set;
    logic [7:0] main_clr;
    logic [7:0] sec_set;
    logic [7:0] tx_set;
    logic [7:0] tx_clr;
    logic [7:0] rx_set;
    logic [7:0] rx_clr;
    logic [7:0] nak_set;
    logic [7:0] fw_level;
    logic [7:0] fw_new;
    logic [7:0] main_view;
    logic [7:0] read_mux;
    logic       buszero_fire;
    logic       idle3_fire;
    logic       idle5_fire;

    // Register strobes.
    wire rd_main  = reg_rd_i && addr_hit(reg_addr_i, `OFF_MAIN_EVENT);
    wire rd_sec   = reg_rd_i && addr_hit(reg_addr_i, `OFF_SEC_EVENT);
    wire rd_rx    = reg_rd_i && addr_hit(reg_addr_i, `OFF_RX_EVENT);
    wire rd_nak   = reg_rd_i && addr_hit(reg_addr_i, `OFF_NAK_EVENT);
    wire rd_fw    = reg_rd_i && addr_hit(reg_addr_i, `OFF_FW_EVENT);
    wire wr_state = reg_wr_i && addr_hit(reg_addr_i, `OFF_NODE_STATE);
    wire asleep   = (node_state_reg == usb_evt_pkg::state_asleep);

    // Bus condition timers on the upstream port.
    level_timer #(.LIMIT(`BUSZERO_CYCLES)) u_buszero (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .level_i  (bus_se0_i),
        .fire_o   (buszero_fire)
    );
    level_timer #(.LIMIT(IDLE3_CYCLES)) u_idle3 (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .level_i  (bus_idle_i),
        .fire_o   (idle3_fire)
    );
    level_timer #(.LIMIT(IDLE5_CYCLES)) u_idle5 (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .level_i  (bus_idle_i),
        .fire_o   (idle5_fire)
    );

    // Secondary events; every bit is cleared by reading the register.
    assign sec_set = {resume_seen_i && asleep,
                      buszero_fire,
                      idle5_fire,
                      idle3_fire,
                      eop_seen_i,
                      3'h0};
    event_flag_bank u_sec (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .set_i    (sec_set),
        .clr_i    ({8{rd_sec}}),
        .flag_o   (sec_q)
    );

    // Transmit copies; endpoint zero stores and forwards so cannot underrun.
    assign tx_set = {tx_underflow_i[3:1], 1'b0, tx_done_i};
    assign tx_clr = {tx_status_read_i[3:1], 1'b1, tx_status_read_i};
    event_flag_bank u_tx (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .set_i    (tx_set),
        .clr_i    (tx_clr),
        .flag_o   (tx_q)
    );

    // Receive copies; endpoint zero drops errored packets, so fault is ignored there.
    assign rx_set = {rx_overrun_i,
                     rx_final_i[3:1] | rx_fault_i[3:1], rx_final_i[0]};
    assign rx_clr = {{4{rd_rx}}, rx_status_read_i};
    event_flag_bank u_rx (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .set_i    (rx_set),
        .clr_i    (rx_clr),
        .flag_o   (rx_q)
    );

    // Handshake refusals, cleared on read.
    assign nak_set = {nak_out_i, nak_in_i};
    event_flag_bank u_nak (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .set_i    (nak_set),
        .clr_i    ({8{rd_nak}}),
        .flag_o   (nak_q)
    );

    // Warning levels follow the FIFOs; only newly raised bits count, else a
    // persisting warning would re-arm the summary right after each read.
    assign fw_level = {rx_warn_i, 1'b0, tx_warn_i, 1'b0};
    assign fw_new   = fw_level & ~fw_prev_reg;

    // Summary flags. Masks gate setting only; flags already set stay set.
    assign main_set[`MAIN_WARN_BIT]   = |(fw_new & fw_mask_reg);
    assign main_set[`MAIN_SEC_BIT]    = |(sec_set & sec_mask_reg);
    assign main_set[`MAIN_TX_BIT]     = |(tx_set & tx_mask_reg);
    assign main_set[`MAIN_FRAME_BIT]  = frame_update_i;
    assign main_set[`MAIN_NAK_BIT]    = |(nak_set & nak_mask_reg);
    assign main_set[`MAIN_LOCK_BIT]   = unlocked_flag_i ^ unlocked_prev_reg;
    assign main_set[`MAIN_RX_BIT]     = |(rx_set & rx_mask_reg);
    assign main_set[`MAIN_MASTER_BIT] = 1'b0;

    // Each summary has a clearing cause, frame and lock sharing the main read; set wins in the bank.
    assign main_clr[`MAIN_WARN_BIT]   = rd_fw;
    assign main_clr[`MAIN_SEC_BIT]    = rd_sec;
    assign main_clr[`MAIN_TX_BIT]     = (tx_q == 8'h00);
    assign main_clr[`MAIN_FRAME_BIT]  = rd_main;
    assign main_clr[`MAIN_NAK_BIT]    = rd_nak;
    assign main_clr[`MAIN_LOCK_BIT]   = rd_main;
    assign main_clr[`MAIN_RX_BIT]     = (rx_q == 8'h00);
    assign main_clr[`MAIN_MASTER_BIT] = 1'b1;
    event_flag_bank u_main (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .set_i    (main_set),
        .clr_i    (main_clr),
        .flag_o   (main_q)
    );
    assign main_view = {1'b0, main_q[6:0]};

    // Interrupt: master enable and any enabled summary flag.
    assign irq_o = main_mask_reg[`MAIN_MASTER_BIT]
                   && |(main_view[6:0] & main_mask_reg[6:0]);

    // Node state decoding drives the transceiver and endpoint controls.
    assign node_state_field_o = node_state_reg;
    assign ep_disable_o       = (node_state_reg == usb_evt_pkg::state_bus_clear);
    assign resume_k_o         = (node_state_reg == usb_evt_pkg::state_wake_signal);
    assign suspend_o          = asleep;
    assign freeze_o           = asleep;

    // Read selection; unmapped addresses and reserved bits read as zero.
    assign read_mux =
        addr_hit(reg_addr_i, `OFF_NODE_STATE) ? {6'h00, node_state_reg} :
        addr_hit(reg_addr_i, `OFF_MAIN_EVENT) ? main_view :
        addr_hit(reg_addr_i, `OFF_MAIN_MASK)  ? main_mask_reg :
        addr_hit(reg_addr_i, `OFF_SEC_EVENT)  ? sec_q :
        addr_hit(reg_addr_i, `OFF_SEC_MASK)   ? sec_mask_reg :
        addr_hit(reg_addr_i, `OFF_TX_EVENT)   ? tx_q :
        addr_hit(reg_addr_i, `OFF_TX_MASK)    ? tx_mask_reg :
        addr_hit(reg_addr_i, `OFF_RX_EVENT)   ? rx_q :
        addr_hit(reg_addr_i, `OFF_RX_MASK)    ? rx_mask_reg :
        addr_hit(reg_addr_i, `OFF_NAK_EVENT)  ? nak_q :
        addr_hit(reg_addr_i, `OFF_NAK_MASK)   ? nak_mask_reg :
        addr_hit(reg_addr_i, `OFF_FW_EVENT)   ? fw_level :
        addr_hit(reg_addr_i, `OFF_FW_MASK)    ? fw_mask_reg : 8'h00;
    assign reg_rdata_o = rdata_reg;

    // Read data is captured on the same edge that clears the read flags.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_reg <= `REG_RESET;
        end else if (reg_rd_i) begin
            rdata_reg <= read_mux;
        end
    end

    // Node state: module reset enters bus clear; software chooses the rest.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            node_state_reg <= usb_evt_pkg::state_bus_clear;
        end else if (wr_state) begin
            node_state_reg <= usb_evt_pkg::node_state_e'(reg_wdata_i[1:0]);
        end
    end

    // Mask registers written by software.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            main_mask_reg <= `REG_RESET;
            sec_mask_reg  <= `REG_RESET;
            tx_mask_reg   <= `REG_RESET;
            rx_mask_reg   <= `REG_RESET;
            nak_mask_reg  <= `REG_RESET;
            fw_mask_reg   <= `REG_RESET;
        end else if (reg_wr_i) begin
            if (addr_hit(reg_addr_i, `OFF_MAIN_MASK)) main_mask_reg <= reg_wdata_i;
            if (addr_hit(reg_addr_i, `OFF_SEC_MASK))  sec_mask_reg  <= {reg_wdata_i[7:3], 3'h0};
            if (addr_hit(reg_addr_i, `OFF_TX_MASK))   tx_mask_reg   <= reg_wdata_i;
            if (addr_hit(reg_addr_i, `OFF_RX_MASK))   rx_mask_reg   <= reg_wdata_i;
            if (addr_hit(reg_addr_i, `OFF_NAK_MASK))  nak_mask_reg  <= reg_wdata_i;
            if (addr_hit(reg_addr_i, `OFF_FW_MASK))   fw_mask_reg   <= reg_wdata_i;
        end
    end

    // Previous levels for edge detection; the lock flag resets to unlocked.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fw_prev_reg       <= `REG_RESET;
            unlocked_prev_reg <= 1'b1;
        end else begin
            fw_prev_reg       <= fw_level;
            unlocked_prev_reg <= unlocked_flag_i;
        end
    end

    // Checks on the behaviour above.
    a_main_top_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        rd_main |=> reg_rdata_o[7] == 1'b0)
        else $error("main event bit 7 read as one");

    a_bus_clear_pipes: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        wr_state && reg_wdata_i[1:0] == 2'h0 |=> ep_disable_o && !resume_k_o)
        else $error("pipes not disabled on bus clear entry");

    a_asleep_freeze: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        node_state_field_o == 2'h3 |-> suspend_o && freeze_o && !ep_disable_o)
        else $error("asleep state without suspend and freeze");

    a_frame_sets: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        frame_update_i |=> main_q[`MAIN_FRAME_BIT])
        else $error("frame update did not set its flag");

    a_lock_change: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        $changed(unlocked_flag_i) |=> main_q[`MAIN_LOCK_BIT])
        else $error("lock change not flagged");

    a_set_beats_read: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        rd_sec && eop_seen_i |=> sec_q[`SEC_EOP_BIT])
        else $error("event lost under clear on read");

    a_buszero_time: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        buszero_fire |-> bus_se0_i && $past(bus_se0_i, 49) ##1 sec_q[`SEC_BUSZERO_BIT])
        else $error("bus zero flag timing wrong");

    a_underrun_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        tx_underflow_i[0] |=> !tx_q[4] && !$rose(tx_q[4]))
        else $error("endpoint zero underrun bit set");

    a_wake_asleep: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        $rose(sec_q[`SEC_WAKE_BIT]) |-> $past(asleep) && $past(resume_seen_i))
        else $error("wake flag set outside asleep state");

    a_irq_master: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !main_mask_reg[`MAIN_MASTER_BIT] || main_mask_reg[6:0] == 7'h00 |-> !irq_o)
        else $error("interrupt without enable");

endmodule

//--- usb_node_event_aggregator_tb.sv
// Purpose: Self-checking bench for event flags, masks, summaries, irq and node state.
// Assumes: Idle timers shortened to 30 and 50 cycles so the run stays short.
// Notes:   Reads compare a byte one cycle after the strobe, as the port registers it.
`timescale 1ns/10ps
module usb_node_event_aggregator_tb;
    logic       clk_i = 1'b0;
    logic       arst_n_i = 1'b0;
    logic [5:0] reg_addr_i = 6'h00;
    logic       reg_wr_i = 1'b0;
    logic       reg_rd_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] reg_rdata_o;
    logic [7:0] rnd;
    logic [5:0] lv;
    logic [3:0] tx_done = 4'h0, tx_uf = 4'h0, tx_rd = 4'h0, rx_fin = 4'h0, rx_ov = 4'h0;
    logic [3:0] rx_rd = 4'h0, nak = 4'h0, rx_flt = 4'h0, nak_o = 4'h0;
    logic [2:0] txw = 3'h0, rxw = 3'h0;
    logic       irq_o, ep_dis, susp, frz, rk;
    logic [1:0] nsf;
    int         num_errors = 0;
    int         cmp_count = 0;

    // 20 MHz core clock.
    always #25 clk_i = ~clk_i;

    upstream_host_model i_upstream_host_model (.clk_i(clk_i), .lv_o(lv));

    usb_node_event_aggregator #(.IDLE3_CYCLES(30), .IDLE5_CYCLES(50)) i_usb_node_event_aggregator (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .bus_se0_i(lv[0]), .bus_idle_i(lv[1]), .resume_seen_i(lv[2]), .eop_seen_i(lv[3]),
        .frame_update_i(lv[4]), .unlocked_flag_i(lv[5]), .tx_done_i(tx_done),
        .tx_underflow_i(tx_uf), .tx_status_read_i(tx_rd), .rx_final_i(rx_fin),
        .rx_fault_i(rx_flt), .rx_overrun_i(rx_ov), .rx_status_read_i(rx_rd), .nak_in_i(nak),
        .nak_out_i(nak_o), .tx_warn_i(txw), .rx_warn_i(rxw), .irq_o(irq_o),
        .node_state_field_o(nsf), .ep_disable_o(ep_dis), .suspend_o(susp),
        .freeze_o(frz), .resume_k_o(rk));

    // Expected control outputs {ep_disable, resume_k, suspend, freeze} for a state code.
    function automatic logic [7:0] ctrl_exp(input logic [1:0] s);
        return {4'h0, s == 2'b00, s == 2'b01, s == 2'b11, s == 2'b11};
    endfunction

    // Counts every comparison and reports a mismatch at once.
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One-cycle write strobe.
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_i) {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
        @(posedge clk_i) reg_wr_i <= 1'b0;
    endtask

    // One-cycle read strobe; the byte is taken once the answering edge has landed.
    task automatic rdc(input logic [5:0] a, input logic [7:0] e);
        @(posedge clk_i) {reg_addr_i, reg_rd_i} <= {a, 1'b1};
        @(posedge clk_i) reg_rd_i <= 1'b0;
        #1 chk($sformatf("reg_%h", a), e, reg_rdata_o);
    endtask

    // Single verdict for the normal end and for the watchdog.
    task automatic wrap_up();
        if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Cuts a hang short; the sequence needs about 22400 cycles, mostly the wake hold.
    initial begin
        #1500000;
        num_errors++;
        wrap_up();
    end

    // Main sequence.
    initial begin
        void'($urandom(99));
        repeat (5) @(posedge clk_i);
        arst_n_i <= 1'b1;
        chk("ctrl", 8'h08, {4'h0, ep_dis, rk, susp, frz});
        for (int a = 6; a <= 18; a++) rdc(a[5:0], 8'h00);
        rdc(6'h3F, 8'h00);
        rnd = 8'($urandom);
        wr(6'h08, rnd);
        rdc(6'h08, rnd);
        wr(6'h0A, rnd);
        rdc(6'h0A, rnd & 8'hF8);
        for (int s = 0; s < 4; s++) begin
            wr(6'h06, s[7:0]);
            rdc(6'h06, s[7:0]);
            chk("ctrl", ctrl_exp(s[1:0]), {4'h0, ep_dis, rk, susp, frz});
            chk("nsf", s[7:0], {6'h00, nsf});
            // Software keeps wake signalling for at least 1 ms (20000 cycles).
            if (s == 1) repeat (20000) @(posedge clk_i);
        end
        wr(6'h06, 8'h02);
        wr(6'h08, 8'h88);
        i_upstream_host_model.hold(4, 1);
        #1 chk("irq", 8'h01, {7'h0, irq_o});
        rdc(6'h07, 8'h08);
        chk("irq", 8'h00, {7'h0, irq_o});
        wr(6'h08, 8'h08);
        i_upstream_host_model.hold(4, 1);
        #1 chk("irq", 8'h00, {7'h0, irq_o});
        rdc(6'h07, 8'h08);
        i_upstream_host_model.set_unlocked(1'b0);
        rdc(6'h07, 8'h20);
        wr(6'h0A, 8'h40);
        i_upstream_host_model.hold(0, 49);
        rdc(6'h09, 8'h00);
        i_upstream_host_model.hold(0, 50);
        rdc(6'h07, 8'h02);
        rdc(6'h09, 8'h40);
        rdc(6'h07, 8'h00);
        wr(6'h06, 8'h00);
        repeat (2000) @(posedge clk_i);
        i_upstream_host_model.hold(1, 40);
        rdc(6'h09, 8'h10);
        i_upstream_host_model.hold(1, 55);
        rdc(6'h09, 8'h30);
        wr(6'h06, 8'h02);
        i_upstream_host_model.hold(2, 1);
        rdc(6'h09, 8'h00);
        wr(6'h06, 8'h03);
        i_upstream_host_model.hold(2, 1);
        i_upstream_host_model.hold(3, 1);
        rdc(6'h09, 8'h88);
        // A read and an event on the same edge: the event must survive the clear.
        fork
            rdc(6'h09, 8'h00);
            i_upstream_host_model.hold(3, 1);
        join
        rdc(6'h09, 8'h08);
        wr(6'h0C, 8'h04);
        @(posedge clk_i) {tx_done, tx_uf} <= {4'h4, 4'h3};
        @(posedge clk_i) {tx_done, tx_uf} <= 8'h00;
        rdc(6'h0B, 8'h24);
        rdc(6'h07, 8'h04);
        @(posedge clk_i) tx_rd <= 4'h6;
        @(posedge clk_i) tx_rd <= 4'h0;
        rdc(6'h0B, 8'h00);
        rdc(6'h07, 8'h00);
        wr(6'h0E, 8'h10);
        @(posedge clk_i) {rx_ov, rx_fin, nak} <= {4'h1, 4'h2, 4'h1};
        @(posedge clk_i) {rx_ov, rx_fin, nak} <= 12'h000;
        rdc(6'h07, 8'h40);
        rdc(6'h0D, 8'h12);
        @(posedge clk_i) rx_rd <= 4'h2;
        @(posedge clk_i) rx_rd <= 4'h0;
        rdc(6'h0D, 8'h00);
        rdc(6'h07, 8'h00);
        rdc(6'h0F, 8'h01);
        // Endpoint zero fault ignored, warning edges gated by mask, NAK on OUT.
        wr(6'h12, 8'h20);
        wr(6'h10, 8'h20);
        @(posedge clk_i) {rx_flt, nak_o, txw, rxw} <= {4'h3, 4'h2, 3'h2, 3'h1};
        @(posedge clk_i) {rx_flt, nak_o} <= 8'h00;
        rdc(6'h0D, 8'h02);
        rdc(6'h07, 8'h11);
        rdc(6'h11, 8'h24);
        rdc(6'h0F, 8'h20);
        rdc(6'h07, 8'h00);
        wrap_up();
    end
endmodule
